//--- refresh_row_counter.sv
`default_nettype none

module refresh_row_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Advance request
  input wire logic advance_i,
  // Current refresh row
  output logic [8:0] row_o
);

  typedef struct packed {
    logic [8:0] row;
  } counter_state_s;

  counter_state_s state_reg;
  counter_state_s state_next;

  // Wraps after the last row so refresh sweeps forever
  always_comb
  begin
    state_next = state_reg;
    if (advance_i)
    begin
      state_next.row = state_reg.row + 9'h001;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '{row: row_decoder_pkg::REFRESH_ROW_RESET};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign row_o = state_reg.row;

endmodule : refresh_row_counter

`default_nettype wire

//--- row_ctrl_model.sv
`default_nettype none
module row_ctrl_model (
  // Clock
  input wire logic clk_i,
  // Row packet pins toward the decoder
  output logic frame_hi_true_bit_o,
  output logic frame_hi_false_bit_o,
  output logic [3:0] packet_device_addr_o,
  output logic activate_select_bit_o,
  output logic [4:0] packet_bank_addr_o,
  output logic [10:0] row_field_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet channel at start
  initial
  begin
    {frame_hi_true_bit_o, frame_hi_false_bit_o, packet_device_addr_o} = 6'h00;
    {activate_select_bit_o, packet_bank_addr_o, row_field_o} = 17'h0;
  end
  // One packet per cycle, all fields in parallel, held a full cycle
  task automatic send(input logic [1:0] fr, input logic [3:0] dev, input logic av,
    input logic [4:0] bnk, input logic [10:0] fld);
    {frame_hi_true_bit_o, frame_hi_false_bit_o} = fr;
    packet_device_addr_o = dev;
    activate_select_bit_o = av;
    packet_bank_addr_o = bnk;
    row_field_o = fld;
    @(negedge clk_i);
  endtask : send
  // No packet; fields scrambled so stale values never look valid
  task automatic idle(input int n);
    repeat (n)
    begin
      {frame_hi_true_bit_o, frame_hi_false_bit_o} = 2'b00;
      packet_device_addr_o = ~packet_device_addr_o;
      packet_bank_addr_o = ~packet_bank_addr_o;
      row_field_o = ~row_field_o;
      @(negedge clk_i);
    end
  endtask : idle
endmodule : row_ctrl_model
`default_nettype wire

//--- row_decoder_pkg.sv
`default_nettype none

package row_decoder_pkg;

  // Packet field widths
  localparam int ID_W = 5;
  localparam int DEV_W = 4;
  localparam int BANK_W = 5;
  localparam int ROW_W = 9;
  localparam int OP_W = 11;

  // Bank address that advances the refresh row
  localparam logic [4:0] TOP_BANK = 5'h1f;

  // Reset values
  localparam logic [8:0] REFRESH_ROW_RESET = 9'h000;
  localparam logic [4:0] ID_RESET = 5'h00;

  // Opcode patterns: a command matches when (op & mask) == value
  localparam logic [10:0] PRECHARGE_MASK = 11'h7c7;
  localparam logic [10:0] PRECHARGE_VAL = 11'h600;
  localparam logic [10:0] REFRESH_MASK = 11'h7f7;
  localparam logic [10:0] REFRESH_ACT_VAL = 11'h0c0;
  localparam logic [10:0] REFRESH_PRE_VAL = 11'h540;
  localparam logic [10:0] POWER_MASK = 11'h1f7;
  localparam logic [10:0] POWERDOWN_VAL = 11'h010;
  localparam logic [10:0] DOZE_VAL = 11'h020;
  localparam logic [10:0] COND_DOZE_VAL = 11'h030;
  localparam logic [10:0] MODE_MASK = 11'h00f;
  localparam logic [10:0] ATTENTION_VAL = 11'h000;
  localparam logic [10:0] STANDBY_VAL = 11'h008;
  localparam logic [10:0] TEMP_MASK = 11'h7f7;
  localparam logic [10:0] TEMP_CAL_VAL = 11'h001;
  localparam logic [10:0] TEMP_CAL_EN_VAL = 11'h002;
  localparam logic [10:0] NO_OP_VAL = 11'h000;

  // Power states, Gray coded along attention-standby-nap-powerdown
  typedef enum logic [1:0] {
    ATTENTION_ST = 2'h0,
    STANDBY_ST = 2'h1,
    DOZE_ST = 2'h3,
    POWERDOWN_ST = 2'h2
  } power_state_e;

  localparam power_state_e POWER_RESET = STANDBY_ST;

endpackage : row_decoder_pkg

`default_nettype wire

//--- row_packet_decoder.sv
`default_nettype none

module row_packet_decoder (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Strapped identifier, from a pin
  input wire logic [4:0] own_device_identifier_i,
  // Row packet fields
  input wire logic frame_hi_true_bit_i,
  input wire logic frame_hi_false_bit_i,
  input wire logic [3:0] packet_device_addr_i,
  input wire logic activate_select_bit_i,
  input wire logic [4:0] packet_bank_addr_i,
  input wire logic [10:0] row_field_i,
  // Condition for conditional nap
  input wire logic doze_allowed_i,
  // Packet decode results
  output logic device_match_o,
  output logic broadcast_o,
  output logic no_operation_o,
  // Bank commands
  output logic activate_o,
  output logic refresh_activate_o,
  output logic precharge_o,
  output logic refresh_precharge_o,
  output logic [4:0] bank_o,
  output logic [8:0] row_o,
  // Temperature commands
  output logic temp_calibrate_o,
  output logic temp_cal_enable_o,
  // Power management
  output logic [1:0] power_state_o,
  output logic cond_doze_request_o,
  // Refresh row counter
  output logic [8:0] refresh_row_counter_o
);

  // All module state except the refresh row, which lives in its own counter
  typedef struct packed {
    logic [4:0] id_meta;
    logic [4:0] id_sync;
    row_decoder_pkg::power_state_e pstate;
    logic match;
    logic bcast;
    logic no_op;
    logic act;
    logic ref_act;
    logic pre;
    logic ref_pre;
    logic [4:0] bank;
    logic [8:0] row;
    logic temp_calibrate_command;
    logic temp_calibrate_command_en;
    logic cond_doze;
  } decoder_state_s;

  decoder_state_s state_reg;
  decoder_state_s state_next;

  logic [8:0] refresh_row;
  logic refresh_advance;
  logic [4:0] frame_id;
  logic match_now;
  logic bcast_now;
  logic op_now;
  logic [10:0] op;
  logic is_pre;
  logic is_ref_act;
  logic is_ref_pre;
  logic is_pdn;
  logic is_doze;
  logic is_cond_doze;
  logic is_attention_state;
  logic is_standby_state;
  logic is_temp_calibrate_command;
  logic is_temp_calibrate_command_en;
  logic any_cmd;
  logic deeper_req;
  row_decoder_pkg::power_state_e deeper_state;
  row_decoder_pkg::power_state_e power_next;

  // Masked opcode compare, shared by every command
  function automatic logic op_hit(
    input logic [10:0] code,
    input logic [10:0] mask,
    input logic [10:0] value
  );
    op_hit = ((code & mask) == value);
  endfunction : op_hit

  // Refresh rows live in their own counter
  refresh_row_counter u_refresh_row_counter (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .advance_i(refresh_advance),
    .row_o(refresh_row)
  );

  // Device selection from merged framing bits
  always_comb
  begin
    frame_id = {frame_hi_true_bit_i, packet_device_addr_i};
    bcast_now = frame_hi_true_bit_i && frame_hi_false_bit_i;
    if (bcast_now)
    begin
      match_now = 1'b1;
    end
    else if (frame_hi_true_bit_i || frame_hi_false_bit_i)
    begin
      match_now = (state_reg.id_sync == frame_id);
    end
    else
    begin
      match_now = 1'b0;
    end
  end

  // Opcode decode; patterns overlap on purpose so commands combine
  always_comb
  begin
    op = row_field_i;
    op_now = match_now && !activate_select_bit_i;
    is_pre = op_hit(op, row_decoder_pkg::PRECHARGE_MASK,
                    row_decoder_pkg::PRECHARGE_VAL);
    is_ref_act = op_hit(op, row_decoder_pkg::REFRESH_MASK,
                        row_decoder_pkg::REFRESH_ACT_VAL);
    is_ref_pre = op_hit(op, row_decoder_pkg::REFRESH_MASK,
                        row_decoder_pkg::REFRESH_PRE_VAL);
    is_pdn = op_hit(op, row_decoder_pkg::POWER_MASK,
                    row_decoder_pkg::POWERDOWN_VAL);
    is_doze = op_hit(op, row_decoder_pkg::POWER_MASK,
                     row_decoder_pkg::DOZE_VAL);
    is_cond_doze = op_hit(op, row_decoder_pkg::POWER_MASK,
                          row_decoder_pkg::COND_DOZE_VAL);
    is_attention_state = op_hit(op, row_decoder_pkg::MODE_MASK,
                     row_decoder_pkg::ATTENTION_VAL);
    is_standby_state = op_hit(op, row_decoder_pkg::MODE_MASK,
                     row_decoder_pkg::STANDBY_VAL);
    is_temp_calibrate_command = op_hit(op, row_decoder_pkg::TEMP_MASK,
                     row_decoder_pkg::TEMP_CAL_VAL);
    is_temp_calibrate_command_en = op_hit(op, row_decoder_pkg::TEMP_MASK,
                        row_decoder_pkg::TEMP_CAL_EN_VAL);
    // All-zero opcode would also read as attention; it is a no-op
    if (op == row_decoder_pkg::NO_OP_VAL)
    begin
      is_attention_state = 1'b0;
    end
    any_cmd = is_pre || is_ref_act || is_ref_pre || is_pdn || is_doze ||
              is_cond_doze || is_attention_state || is_standby_state || is_temp_calibrate_command || is_temp_calibrate_command_en;
  end

  // Counter steps only after the top bank has been refreshed
  assign refresh_advance = op_now && is_ref_act &&
                           (packet_bank_addr_i == row_decoder_pkg::TOP_BANK);

  // Deeper target of a combined opcode; powerdown outranks nap
  always_comb
  begin
    deeper_req = is_pdn || is_doze || (is_cond_doze && doze_allowed_i);
    if (is_pdn)
    begin
      deeper_state = row_decoder_pkg::POWERDOWN_ST;
    end
    else
    begin
      deeper_state = row_decoder_pkg::DOZE_ST;
    end
  end

  // Power state machine; a refused conditional nap falls back to standby or attention
  always_comb
  begin
    power_next = state_reg.pstate;
    if (match_now && activate_select_bit_i)
    begin
      // Activate wakes the device even when broadcast
      power_next = row_decoder_pkg::ATTENTION_ST;
    end
    else if (op_now)
    begin
      case (state_reg.pstate)
        row_decoder_pkg::ATTENTION_ST:
        begin
          // Already awake, so attention itself changes nothing
          if (deeper_req)
          begin
            power_next = deeper_state;
          end
          else if (is_standby_state)
          begin
            power_next = row_decoder_pkg::STANDBY_ST;
          end
        end
        row_decoder_pkg::STANDBY_ST,
        row_decoder_pkg::DOZE_ST,
        row_decoder_pkg::POWERDOWN_ST:
        begin
          if (deeper_req)
          begin
            power_next = deeper_state;
          end
          else if (is_standby_state)
          begin
            power_next = row_decoder_pkg::STANDBY_ST;
          end
          else if (is_attention_state && !bcast_now)
          begin
            // A broadcast must not wake every device at once
            power_next = row_decoder_pkg::ATTENTION_ST;
          end
        end
        default:
        begin
          power_next = state_reg.pstate;
        end
      endcase
    end
  end

  // Next state
  always_comb
  begin
    state_next = state_reg;
    // Identifier strap passes two flops before use
    state_next.id_meta = own_device_identifier_i;
    state_next.id_sync = state_reg.id_meta;
    // Command outputs are one-cycle pulses
    state_next.match = match_now;
    state_next.bcast = bcast_now;
    state_next.no_op = 1'b0;
    state_next.act = 1'b0;
    state_next.ref_act = 1'b0;
    state_next.pre = 1'b0;
    state_next.ref_pre = 1'b0;
    state_next.temp_calibrate_command = 1'b0;
    state_next.temp_calibrate_command_en = 1'b0;
    state_next.cond_doze = 1'b0;
    // Power moves come from the state machine above
    state_next.pstate = power_next;
    if (match_now && activate_select_bit_i)
    begin
      // Upper two row bits are reserved and ignored
      state_next.act = 1'b1;
      state_next.bank = packet_bank_addr_i;
      state_next.row = row_field_i[8:0];
    end
    else if (op_now)
    begin
      state_next.bank = packet_bank_addr_i;
      state_next.no_op = !any_cmd;
      // Every bank and temperature hit fires; power hits go through the state machine, which makes one move
      state_next.pre = is_pre || is_ref_pre;
      state_next.ref_pre = is_ref_pre;
      state_next.ref_act = is_ref_act;
      if (is_ref_act)
      begin
        state_next.row = refresh_row;
      end
      state_next.temp_calibrate_command = is_temp_calibrate_command;
      state_next.temp_calibrate_command_en = is_temp_calibrate_command_en;
      state_next.cond_doze = is_cond_doze;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '{
        id_meta: row_decoder_pkg::ID_RESET,
        id_sync: row_decoder_pkg::ID_RESET,
        pstate: row_decoder_pkg::POWER_RESET,
        match: 1'b0,
        bcast: 1'b0,
        no_op: 1'b0,
        act: 1'b0,
        ref_act: 1'b0,
        pre: 1'b0,
        ref_pre: 1'b0,
        bank: 5'h00,
        row: 9'h000,
        temp_calibrate_command: 1'b0,
        temp_calibrate_command_en: 1'b0,
        cond_doze: 1'b0
      };
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign device_match_o = state_reg.match;
  assign broadcast_o = state_reg.bcast;
  assign no_operation_o = state_reg.no_op;
  assign activate_o = state_reg.act;
  assign refresh_activate_o = state_reg.ref_act;
  assign precharge_o = state_reg.pre;
  assign refresh_precharge_o = state_reg.ref_pre;
  assign bank_o = state_reg.bank;
  assign row_o = state_reg.row;
  assign temp_calibrate_o = state_reg.temp_calibrate_command;
  assign temp_cal_enable_o = state_reg.temp_calibrate_command_en;
  assign power_state_o = state_reg.pstate;
  assign cond_doze_request_o = state_reg.cond_doze;
  assign refresh_row_counter_o = refresh_row;

endmodule : row_packet_decoder

`default_nettype wire

//--- row_packet_decoder_bench.sv
`default_nettype none
module row_packet_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset, strap and pins
  logic clk_i, rst_n_i, doze_ok, ft, ff, av;
  logic [4:0] dev_id, ba, bank;
  logic [3:0] da;
  logic [10:0] rf;
  logic dm, bc, nop, act, ract, pre, rpre, tc, te, cdz;
  logic [8:0] row, cnt;
  logic [1:0] ps;
  int fail_count, tests_run;
  // Controller model and decoder
  row_ctrl_model ctl (.clk_i(clk_i), .frame_hi_true_bit_o(ft), .frame_hi_false_bit_o(ff),
    .packet_device_addr_o(da), .activate_select_bit_o(av), .packet_bank_addr_o(ba), .row_field_o(rf));
  row_packet_decoder dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .own_device_identifier_i(dev_id),
    .frame_hi_true_bit_i(ft), .frame_hi_false_bit_i(ff), .packet_device_addr_i(da),
    .activate_select_bit_i(av), .packet_bank_addr_i(ba), .row_field_i(rf),
    .doze_allowed_i(doze_ok), .device_match_o(dm), .broadcast_o(bc), .no_operation_o(nop),
    .activate_o(act), .refresh_activate_o(ract), .precharge_o(pre), .refresh_precharge_o(rpre),
    .bank_o(bank), .row_o(row), .temp_calibrate_o(tc), .temp_cal_enable_o(te),
    .power_state_o(ps), .cond_doze_request_o(cdz), .refresh_row_counter_o(cnt));
  // 10 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Packet to device 4'ha; flags {match,bcast,nop,act,ract,pre,rpre,tc,te,cdz,state}
  task automatic run(input logic [1:0] fr, input logic a, input logic [4:0] b,
    input logic [10:0] op, input logic dz, input logic [11:0] exp);
    doze_ok = dz;
    ctl.send(fr, 4'ha, a, b, op);
    check({20'h0, dm, bc, nop, act, ract, pre, rpre, tc, te, cdz, ps}, {20'h0, exp});
    if (exp[11])
      check({27'h0, bank}, {27'h0, b});
  endtask : run
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // Watchdog, far beyond the few dozen cycles needed
  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end
  // Sequence; power state leaves reset in standby
  initial
  begin
    {rst_n_i, doze_ok, dev_id, fail_count, tests_run} = '0;
    dev_id = 5'h0a;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    ctl.idle(2);
    run(2'b01, 1'b1, 5'h03, 11'h005, 1'b0, 12'h900);
    check({23'h0, row}, {23'h0, 9'h005});
    run(2'b10, 1'b1, 5'h03, 11'h005, 1'b0, 12'h000);
    run(2'b00, 1'b1, 5'h04, 11'h005, 1'b0, 12'h000);
    run(2'b01, 1'b0, 5'h05, 11'h008, 1'b0, 12'h801);
    run(2'b11, 1'b0, 5'h06, 11'h600, 1'b0, 12'hc41);
    run(2'b01, 1'b0, 5'h07, 11'h600, 1'b0, 12'h840);
    run(2'b01, 1'b0, 5'h08, 11'h020, 1'b0, 12'h803);
    run(2'b01, 1'b0, 5'h09, 11'h410, 1'b0, 12'h802);
    run(2'b01, 1'b0, 5'h0a, 11'h000, 1'b0, 12'ha02);
    run(2'b01, 1'b0, 5'h0b, 11'h004, 1'b0, 12'ha02);
    run(2'b01, 1'b1, 5'h03, 11'h005, 1'b0, 12'h900);
    run(2'b01, 1'b0, 5'h0c, 11'h030, 1'b0, 12'h804);
    run(2'b01, 1'b0, 5'h0d, 11'h030, 1'b1, 12'h807);
    run(2'b01, 1'b0, 5'h1f, 11'h0c0, 1'b0, 12'h880);
    check({14'h0, row, cnt}, {14'h0, 9'h000, 9'h001});
    run(2'b01, 1'b0, 5'h1e, 11'h0c0, 1'b0, 12'h880);
    check({14'h0, row, cnt}, {14'h0, 9'h001, 9'h001});
    run(2'b01, 1'b0, 5'h1e, 11'h540, 1'b0, 12'h860);
    run(2'b01, 1'b0, 5'h02, 11'h001, 1'b0, 12'h810);
    run(2'b01, 1'b0, 5'h02, 11'h002, 1'b0, 12'h808);
    run(2'b01, 1'b0, 5'h02, 11'h638, 1'b1, 12'h847);
    run(2'b11, 1'b0, 5'h02, 11'h600, 1'b0, 12'hc43);
    run(2'b11, 1'b0, 5'h02, 11'h010, 1'b0, 12'hc02);
    dev_id = 5'h1a;
    ctl.idle(3);
    run(2'b10, 1'b0, 5'h02, 11'h008, 1'b0, 12'h801);
    run(2'b01, 1'b0, 5'h02, 11'h008, 1'b0, 12'h001);
    wrap_up();
  end
endmodule : row_packet_decoder_bench
`default_nettype wire

//--- row_packet_decoder_sva.sv
`default_nettype none
module row_packet_checker (
  // Clock, reset and packet pins
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic frame_hi_true_bit_i,
  input wire logic frame_hi_false_bit_i,
  input wire logic activate_select_bit_i,
  input wire logic [10:0] row_field_i,
  // Decoder results
  input wire logic device_match_o,
  input wire logic broadcast_o,
  input wire logic activate_o,
  input wire logic refresh_activate_o,
  input wire logic precharge_o,
  input wire logic refresh_precharge_o,
  input wire logic [4:0] bank_o,
  input wire logic [8:0] row_o,
  input wire logic [1:0] power_state_o,
  input wire logic [8:0] refresh_row_counter_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Short aliases; opcode only counts when framed and not an activate
  logic hi, lo, rq;
  logic [10:0] op;
  logic [8:0] ra;
  assign hi = frame_hi_true_bit_i;
  assign lo = frame_hi_false_bit_i;
  assign op = row_field_i;
  assign ra = row_field_i[8:0];
  assign rq = (hi | lo) & !activate_select_bit_i;
  chk_bcast_match: assert property (
    hi && lo |=> device_match_o && broadcast_o) else $error("broadcast not matched");
  chk_no_frame: assert property (
    !hi && !lo |=> !device_match_o && !activate_o && !precharge_o && !refresh_activate_o)
    else $error("unframed packet acted on");
  chk_activate_row: assert property (
    (hi || lo) && activate_select_bit_i |=> activate_o == device_match_o
    && (!activate_o || (row_o == $past(ra) && power_state_o == 2'h0))) else $error("bad activate");
  chk_precharge_hit: assert property (
    rq && (op & 11'h7c7) == 11'h600 |=> precharge_o == device_match_o) else $error("bad precharge");
  chk_refresh_pre: assert property (
    rq && (op & 11'h7f7) == 11'h540 |=> refresh_precharge_o == device_match_o
    && precharge_o == device_match_o) else $error("bad refresh precharge");
  chk_counter_step: assert property (
    refresh_activate_o && bank_o == 5'h1f |-> refresh_row_counter_o == row_o + 9'h001)
    else $error("refresh row did not advance");
  chk_counter_cause: assert property (
    refresh_row_counter_o != $past(refresh_row_counter_o) |-> refresh_activate_o && bank_o == 5'h1f)
    else $error("refresh row moved without cause");
  chk_powerdown_go: assert property (
    rq && (op & 11'h1f7) == 11'h010 |=> !device_match_o || power_state_o == 2'h2)
    else $error("powerdown not entered");
  chk_bcast_attention_state: assert property (
    hi && lo && !activate_select_bit_i && op == 11'h600 && power_state_o != 2'h0
    |=> $stable(power_state_o)) else $error("broadcast woke device");
  // Main scenarios seen
  cov_refresh_wrap: cover property (refresh_activate_o && bank_o == 5'h1f);
  cov_bcast_power: cover property (broadcast_o && power_state_o == 2'h2);
  cov_activate: cover property (activate_o && power_state_o == 2'h0);
endmodule : row_packet_checker

bind row_packet_decoder row_packet_checker chk (
  .clk_i, .rst_n_i, .frame_hi_true_bit_i, .frame_hi_false_bit_i, .activate_select_bit_i,
  .row_field_i, .device_match_o, .broadcast_o, .activate_o, .refresh_activate_o, .precharge_o,
  .refresh_precharge_o, .bank_o, .row_o, .power_state_o, .refresh_row_counter_o
);
`default_nettype wire
